// ==== spimr_top.v ====
// spi master port with control, status and data registers on axi4-lite
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "spimr_regs.vh"
module spimr_top (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// axi4-lite write address
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	// axi4-lite write data
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	// axi4-lite write response
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	input wire [31:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	// axi4-lite read data
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	// serial pins
	output reg spi_sck,
	output reg spi_mosi,
	input wire spi_miso,
	input wire spi_ss_n,
	input wire ext_brg_clk,
	// interrupt requests
	output reg irq_xfer,
	output reg irq_err
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [7:0] merge_byte;
	input [7:0] old;
	input [31:0] wdata;
	input [3:0] strb;
	begin
		merge_byte = strb[0] ? wdata[7:0] : old;
	end
endfunction

function mapped;
	input [`SPIMR_ADDR_W-1:0] ofs;
	begin
		mapped = (ofs == `SPIMR_OFS_CTRL) || (ofs == `SPIMR_OFS_STAT) ||
			(ofs == `SPIMR_OFS_DATA) || (ofs == `SPIMR_OFS_MSEL);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [2:0] pins_s;
wire miso_s;
wire ss_n_s;
wire brg_s;

spimr_sync #(
	.WIDTH(3),
	.INIT(3'h2)
) u_sync (
	.core_clk(core_clk),
	.rst(rst),
	.async_in({ext_brg_clk, spi_ss_n, spi_miso}),
	.sync_out(pins_s)
);

assign miso_s = pins_s[0];
assign ss_n_s = pins_s[1];
assign brg_s = pins_s[2];

////////////////////////////////////////////////////////////////////////////////
// state

reg [7:0] ctrl_r;
reg master_r;
reg tc_r;
reg write_collision_flag_r;
reg mode_fault_flag_r;
reg arm_tc_r;
reg arm_write_collision_flag_r;
reg arm_mode_fault_flag_r;
reg [7:0] rxbuf_r;
reg [7:0] sh_r;
reg [3:0] edge_r;
reg [1:0] state_r;
reg ss_q_r;
localparam [1:0] ST_IDLE = `SPIMR_ST_IDLE;
localparam [1:0] ST_SHIFT = `SPIMR_ST_SHIFT;

// write channel holding
reg aw_full_r;
reg [`SPIMR_ADDR_W-1:0] aw_addr_r;
reg w_full_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;

wire [2:0] rate;
wire tick;
wire busy;
wire do_write;
wire ar_take;
wire [`SPIMR_ADDR_W-1:0] ar_ofs;
wire wr_ctrl;
wire wr_data;
wire wr_msel;
wire wr_stat;
wire rd_stat;
wire rd_data;
wire ss_fall;
wire fault;
wire start;
wire finish;
wire lead;
wire sample_edge;
wire [7:0] sh_in;
wire [7:0] stat_val;

assign rate = {ctrl_r[`SPIMR_CTRL_RATE2], ctrl_r[`SPIMR_CTRL_RATE1],
	ctrl_r[`SPIMR_CTRL_RATE0]};
assign busy = (state_r == ST_SHIFT);

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
assign ar_take = s_axi_arvalid & s_axi_arready;
assign ar_ofs = s_axi_araddr[`SPIMR_ADDR_W-1:0];

// registers reachable at any time, busy or not
assign wr_ctrl = do_write && (aw_addr_r == `SPIMR_OFS_CTRL);
assign wr_stat = do_write && (aw_addr_r == `SPIMR_OFS_STAT);
assign wr_data = do_write && (aw_addr_r == `SPIMR_OFS_DATA);
assign wr_msel = do_write && (aw_addr_r == `SPIMR_OFS_MSEL);
assign rd_stat = ar_take && (ar_ofs == `SPIMR_OFS_STAT);
assign rd_data = ar_take && (ar_ofs == `SPIMR_OFS_DATA);

// unused status bits read as zero
assign stat_val = {tc_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		aw_full_r <= 1'b0;
		aw_addr_r <= {`SPIMR_ADDR_W{1'b0}};
		w_full_r <= 1'b0;
		w_data_r <= 32'h0000_0000;
		w_strb_r <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SPIMR_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr[`SPIMR_ADDR_W-1:0];
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_full_r <= 1'b0;
			s_axi_awready <= 1'b1;
		end else begin
			s_axi_awready <= ~aw_full_r;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_full_r <= 1'b0;
			s_axi_wready <= 1'b1;
		end else begin
			s_axi_wready <= ~w_full_r;
		end
		if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_addr_r) ? `SPIMR_RESP_OKAY :
				`SPIMR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `SPIMR_RESP_OKAY;
	end else begin
		if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(ar_ofs) ? `SPIMR_RESP_OKAY :
				`SPIMR_RESP_SLVERR;
			case (ar_ofs)
			`SPIMR_OFS_CTRL: begin
				s_axi_rdata <= {24'h000000, ctrl_r};
			end
			`SPIMR_OFS_STAT: begin
				s_axi_rdata <= {24'h000000, stat_val};
			end
			`SPIMR_OFS_DATA: begin
				s_axi_rdata <= {24'h000000, rxbuf_r};
			end
			`SPIMR_OFS_MSEL: begin
				s_axi_rdata <= {31'h00000000, master_r};
			end
			default: begin
				s_axi_rdata <= 32'h0000_0000;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= ~s_axi_rvalid;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control, master select and mode fault

assign ss_fall = ss_q_r & ~ss_n_s;
assign fault = ss_fall & master_r;

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		ctrl_r <= `SPIMR_CTRL_RST;
		master_r <= `SPIMR_MSEL_RST;
		ss_q_r <= 1'b1;
	end else begin
		ss_q_r <= ss_n_s;
		// bits 5 and 4 are stored as written; software keeps them
		if (wr_ctrl) begin
			ctrl_r <= merge_byte(ctrl_r, w_data_r, w_strb_r);
		end
		if (wr_msel) begin
			master_r <= merge_byte({7'h00, master_r}, w_data_r,
				w_strb_r) != 8'h00;
		end
		// the fault wins over a write in the same cycle
		if (fault) begin
			ctrl_r[`SPIMR_CTRL_EN] <= 1'b0;
			master_r <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// status flags and their clearing sequences

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		tc_r <= 1'b0;
		write_collision_flag_r <= 1'b0;
		mode_fault_flag_r <= 1'b0;
		arm_tc_r <= 1'b0;
		arm_write_collision_flag_r <= 1'b0;
		arm_mode_fault_flag_r <= 1'b0;
	end else begin
		// status read with the flag set arms its clear
		if (rd_stat && tc_r) begin
			arm_tc_r <= 1'b1;
		end else if (rd_data) begin
			arm_tc_r <= 1'b0;
		end
		if ((rd_stat || wr_stat) && write_collision_flag_r) begin
			arm_write_collision_flag_r <= 1'b1;
		end else if (rd_data || wr_data) begin
			arm_write_collision_flag_r <= 1'b0;
		end
		if (rd_stat && mode_fault_flag_r) begin
			arm_mode_fault_flag_r <= 1'b1;
		end else if (wr_ctrl) begin
			arm_mode_fault_flag_r <= 1'b0;
		end
		// set wins over clear in every flag
		if (finish) begin
			tc_r <= 1'b1;
		end else if (start || (rd_data && arm_tc_r)) begin
			tc_r <= 1'b0;
		end
		if (wr_data && busy) begin
			write_collision_flag_r <= 1'b1;
		end else if ((rd_data || wr_data) && arm_write_collision_flag_r) begin
			write_collision_flag_r <= 1'b0;
		end
		if (fault) begin
			mode_fault_flag_r <= 1'b1;
		end else if (wr_ctrl && arm_mode_fault_flag_r) begin
			mode_fault_flag_r <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// shift engine

// a write while busy is a collision and never restarts the shift
assign start = wr_data && !busy && ctrl_r[`SPIMR_CTRL_EN] &&
	master_r && w_strb_r[0];
assign lead = ~edge_r[0];
assign sample_edge = ctrl_r[`SPIMR_CTRL_CLOCK_SAMPLE_EDGE] ? ~lead : lead;
assign sh_in = {sh_r[6:0], miso_s};
assign finish = busy && tick && (edge_r == `SPIMR_LAST_EDGE) &&
	ctrl_r[`SPIMR_CTRL_EN];

spimr_rate_gen u_rate (
	.core_clk(core_clk),
	.rst(rst),
	.run(busy),
	.rate(rate),
	.brg_sync(brg_s),
	.tick(tick)
);

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		state_r <= ST_IDLE;
		edge_r <= 4'h0;
		sh_r <= 8'h00;
		rxbuf_r <= 8'h00; // any value is acceptable here
		spi_sck <= 1'b0;
		spi_mosi <= 1'b0;
	end else begin
		case (state_r)
		ST_IDLE: begin
			spi_sck <= ctrl_r[`SPIMR_CTRL_CLOCK_IDLE_LEVEL];
			edge_r <= 4'h0;
			if (start) begin
				sh_r <= w_data_r[7:0];
				// leading bit is out before the first edge with phase 0
				if (!ctrl_r[`SPIMR_CTRL_CLOCK_SAMPLE_EDGE]) begin
					spi_mosi <= w_data_r[7];
				end
				state_r <= ST_SHIFT;
			end
		end
		ST_SHIFT: begin
			if (!ctrl_r[`SPIMR_CTRL_EN]) begin
				// abort without completing the byte
				state_r <= ST_IDLE;
				spi_sck <= ctrl_r[`SPIMR_CTRL_CLOCK_IDLE_LEVEL];
			end else if (tick) begin
				spi_sck <= ~spi_sck;
				edge_r <= edge_r + 4'h1;
				if (sample_edge) begin
					sh_r <= sh_in;
				end else begin
					spi_mosi <= sh_r[7];
				end
				if (edge_r == `SPIMR_LAST_EDGE) begin
					rxbuf_r <= sample_edge ? sh_in : sh_r;
					state_r <= ST_IDLE;
				end
			end
		end
		default: begin
			state_r <= ST_IDLE;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt requests; collision has none

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		irq_xfer <= 1'b0;
		irq_err <= 1'b0;
	end else begin
		irq_xfer <= tc_r;
		irq_err <= mode_fault_flag_r;
	end
end

endmodule // spimr_top

// ==== spimr_regs.vh ====
// register map, field positions and codes of the spi master port
`ifndef SPIMR_REGS_VH
`define SPIMR_REGS_VH

// byte offsets on the register bus
`define SPIMR_OFS_CTRL 4'h0
`define SPIMR_OFS_STAT 4'h4
`define SPIMR_OFS_DATA 4'h8
`define SPIMR_OFS_MSEL 4'hc
`define SPIMR_ADDR_W 4

// control register fields
`define SPIMR_CTRL_RATE2 7
`define SPIMR_CTRL_EN 6
`define SPIMR_CTRL_RSV0 5
`define SPIMR_CTRL_RSV1 4
`define SPIMR_CTRL_CLOCK_IDLE_LEVEL 3
`define SPIMR_CTRL_CLOCK_SAMPLE_EDGE 2
`define SPIMR_CTRL_RATE1 1
`define SPIMR_CTRL_RATE0 0
`define SPIMR_CTRL_RST 8'h14

// status register fields
`define SPIMR_STAT_TC 7
`define SPIMR_STAT_WRITE_COLLISION_FLAG 6
`define SPIMR_STAT_MODE_FAULT_FLAG 4

// master select register
`define SPIMR_MSEL_BIT 0
`define SPIMR_MSEL_RST 1'b1

// rate code that selects the external baud rate generator
`define SPIMR_RATE_EXT 3'h7

// axi responses
`define SPIMR_RESP_OKAY 2'h0
`define SPIMR_RESP_SLVERR 2'h2

// bit edges per byte, minus one
`define SPIMR_LAST_EDGE 4'hf

// transfer states, one-hot
`define SPIMR_ST_IDLE 2'h1
`define SPIMR_ST_SHIFT 2'h2

`endif

// ==== spimr_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module spimr_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// pins in, synchronised out
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		meta_r <= INIT;
		sync_out <= INIT;
	end else begin
		meta_r <= async_in;
		sync_out <= meta_r;
	end
end

endmodule // spimr_sync

// ==== spimr_rate_gen.v ====
// half-period tick generator for the serial clock
`timescale 1ns/1ns
`include "spimr_regs.vh"
module spimr_rate_gen (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// control
	input wire run,
	input wire [2:0] rate,
	input wire brg_sync,
	// one pulse per serial clock edge
	output reg tick
);

reg [6:0] cnt_r;
reg brg_q_r;
wire [6:0] half_last;
wire brg_rise;

// half period of 2^rate core cycles gives a divide by 2^(rate+1)
assign half_last = (7'h01 << rate) - 7'h01;
assign brg_rise = brg_sync & ~brg_q_r;

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		cnt_r <= 7'h00;
		brg_q_r <= 1'b0;
		tick <= 1'b0;
	end else begin
		brg_q_r <= brg_sync;
		if (!run) begin
			cnt_r <= 7'h00;
			tick <= 1'b0;
		end else if (rate == `SPIMR_RATE_EXT) begin
			cnt_r <= 7'h00;
			tick <= brg_rise;
		end else if (cnt_r == half_last) begin
			cnt_r <= 7'h00;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 7'h01;
			tick <= 1'b0;
		end
	end
end

endmodule // spimr_rate_gen

// ==== spimr_chk_asserts.sv ====
// port assertions for the spi master port
`timescale 1ns/1ns
module spimr_chk (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// serial clock and requests
	input wire spi_sck,
	input wire irq_xfer,
	input wire irq_err
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_B_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_R_UPPER: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_W_ANSWER: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	AST_R_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_XFER_END: assert property (
		$rose(irq_xfer) |-> $past(spi_sck) != $past(spi_sck, 2))
		else $error("transfer flag without last clock edge");
	AST_XFER_CLR: assert property (
		$fell(irq_xfer) |-> $past(s_axi_rvalid) || $past(s_axi_rvalid, 2)
		|| $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("transfer flag cleared without access");
	AST_ERR_CLR: assert property (
		$fell(irq_err) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("fault cleared without write");
	AST_ERR_QUIET: assert property (
		$rose(irq_err) |=> $stable(spi_sck) [*4])
		else $error("serial clock runs after fault");
endmodule // spimr_chk

bind spimr_top spimr_chk u_chk (.*);

// ==== spimr_slave.sv ====
// behavioural spi slave at the far end of the serial pins
`timescale 1ns/1ns
module spimr_slave (
	// serial pins
	input wire spi_sck,
	input wire spi_mosi,
	output logic spi_miso,
	// setup from the bench
	input wire sel,
	input wire clock_idle_level,
	input wire clock_sample_edge,
	input wire [7:0] tx,
	output logic [7:0] rx
);
	logic [7:0] sh;
	initial spi_miso = 1'b0;
	always @(posedge sel) begin
		sh = tx;
		spi_miso = tx[7];
	end
	// released line must not keep its last bit
	always @(negedge sel) spi_miso = ~spi_miso;
	always @(spi_sck) begin
		if (sel && ((spi_sck != clock_idle_level) ^ clock_sample_edge)) begin
			rx = {rx[6:0], spi_mosi};
		end else if (sel) begin
			if (!clock_sample_edge) sh = {sh[6:0], 1'b1};
			spi_miso = sh[7];
			if (clock_sample_edge) sh = {sh[6:0], 1'b1};
		end
	end
endmodule // spimr_slave

// ==== tb.sv ====
// self-checking bench of the spi master port
`timescale 1ns/1ns
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic spi_ss_n = 1'b1, ext_brg_clk = 1'b0;
	logic sel = 1'b0, clock_idle_level = 1'b0, clock_sample_edge = 1'b0;
	logic [7:0] tx = 8'h0, c, t, h;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire spi_sck, spi_mosi, spi_miso, irq_xfer, irq_err;
	wire [7:0] rx;
	// control, byte out, slave byte, half period in cycles
	logic [31:0] rows [8] = '{32'h50a5ff01, 32'h593cff02, 32'h56815a04,
		32'h5f7ec308, 32'hd0019610, 32'hd9c46920, 32'hd6e72440, 32'hd35ba614};
	int err_count = 0, compares = 0, i, n, k;

	spimr_top dut (.*);
	spimr_slave u_slave (.*);

	always #4 core_clk = ~core_clk;
	always #80 ext_brg_clk = ~ext_brg_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic hang;
		err_count++;
		$display("BAD wait expected done seen timeout");
		end_sim;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input [3:0] a, input [7:0] d, input [1:0] er = 2'h0);
		int m;
		m = 0;
		@(posedge core_clk);
		s_axi_awaddr <= {28'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			m++;
		end while (!(s_axi_bvalid && s_axi_bready) && m < 99);
		if (m >= 99) hang;
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, er);
	endtask

	task automatic rd(input [3:0] a, input [7:0] e, input [1:0] er = 2'h0);
		int m;
		m = 0;
		@(posedge core_clk);
		s_axi_araddr <= {28'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			m++;
		end while (!s_axi_rvalid && m < 99);
		if (m >= 99) hang;
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, {24'h0, e});
		chk("rresp", s_axi_rresp, er);
	endtask

	task automatic tog(output int m);
		logic s;
		s = spi_sck;
		m = 0;
		do begin
			@(posedge core_clk);
			m++;
		end while (spi_sck === s && m < 3000);
		if (m >= 3000) hang;
	endtask

	task automatic wirq;
		int m;
		m = 0;
		while (irq_xfer !== 1'b1 && m < 3000) begin
			@(posedge core_clk);
			m++;
		end
		if (m >= 3000) hang;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h0, 8'h14);
		rd(4'h4, 8'h00);
		rd(4'hc, 8'h01);
		rd(4'h6, 8'h00, 2'h2);
		wr(4'h6, 8'h5a, 2'h2);
		for (i = 0; i < 8; i++) begin
			{c, t, tx, h} = rows[i];
			{clock_idle_level, clock_sample_edge} = c[3:2];
			wr(4'h0, c);
			repeat (2) @(posedge core_clk);
			chk("idle", spi_sck, c[3]);
			sel <= 1'b1;
			wr(4'h8, t);
			tog(n);
			tog(n);
			chk("half", n, h);
			wirq;
			sel <= 1'b0;
			chk("mosi", rx, t);
			rd(4'h4, 8'h80);
			rd(4'h8, tx);
			rd(4'h4, 8'h00);
		end
		{clock_idle_level, clock_sample_edge} = 2'b01;
		tx = 8'h33;
		wr(4'h0, 8'h56);
		sel <= 1'b1;
		wr(4'h8, 8'hc9);
		tog(n);
		wr(4'h8, 8'h12);
		wirq;
		sel <= 1'b0;
		chk("keep", rx, 8'hc9);
		chk("noerr", irq_err, 1'b0);
		rd(4'h4, 8'hc0);
		rd(4'h8, 8'h33);
		rd(4'h4, 8'h00);
		wr(4'h0, 8'hd6);
		sel <= 1'b1;
		wr(4'h8, 8'hff);
		tog(n);
		// rate, polarity and phase kept while the enable drops
		wr(4'h0, 8'h96);
		wr(4'h8, 8'h55);
		k = 0;
		repeat (300) begin
			@(posedge core_clk);
			if (spi_sck !== 1'b0 || irq_xfer !== 1'b0) k++;
		end
		chk("abort", k, 32'h0);
		sel <= 1'b0;
		rd(4'h4, 8'h00);
		wr(4'h0, 8'h56);
		spi_ss_n <= 1'b0;
		n = 0;
		while (irq_err !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		chk("fault", irq_err, 1'b1);
		spi_ss_n <= 1'b1;
		rd(4'h0, 8'h16);
		rd(4'hc, 8'h00);
		rd(4'h4, 8'h10);
		wr(4'h0, 8'h56);
		rd(4'h4, 8'h00);
		chk("clear", irq_err, 1'b0);
		wr(4'hc, 8'h01);
		// low byte lane off: the write must leave the register alone
		s_axi_wstrb <= 4'he;
		wr(4'hc, 8'h00);
		s_axi_wstrb <= 4'hf;
		rd(4'hc, 8'h01);
		end_sim;
	end
endmodule // tb
